// file: design/sbsa_pkg.sv
// Constants shared by the burst SRAM access front end.
// Assumes a single 25 MHz system clock.
package sbsa_pkg;
	localparam int          SBSA_LANES     = 4;
	localparam int          SBSA_LANE_W    = 8;
	localparam int          SBSA_DATA_W    = SBSA_LANES * SBSA_LANE_W;
	localparam int          SBSA_BURST_W   = 2;
	localparam logic [1:0]  SBSA_STEP_RST  = 2'h0;
	localparam logic [1:0]  SBSA_STEP_ONE  = 2'h1;
	localparam logic        SBSA_MODE_RST  = 1'h1;

	typedef enum logic [2:0] {
		SBSA_ST_DESEL = 3'h1,
		SBSA_ST_READ  = 3'h2,
		SBSA_ST_WRITE = 3'h4
	} sbsa_state_type;
endpackage

// file: design/sbsa_top.sv
// Synchronous flow-through burst SRAM: input registers, strobes, burst counter, core and data turnaround.
// Assumes the bus master shares clk_in and resolves the shared data wire from dq_oe_out.
//
// Contract
// - Every synchronous input is registered on the rising clock edge.
// - Either address strobe low at a clock rise may start an access.
// - Processor strobe ignored while first select high; selected needs all three selects.
// - Selected plus a strobe starts an access and loads address and burst counter.
// - Read data driven only while output enable low; enable acts asynchronously.
// - Processor-strobe start ignores all write controls and always begins as read.
// - Write indicated at the next rise after processor start writes selected bytes.
// - Controller strobe, processor strobe high, write indicated: write data that cycle.
// - Both strobes low with first select low: processor strobe alone is acted upon.
// - Byte writes need qualify and lane select; global write writes every lane.
// - Any detected write cycle floats all data pins regardless of output enable.
// - Two-bit wraparound burst counter loaded from low address bits.
// - Burst counter steps only while the advance input is low.
// - Strap low gives linear order, high gives interleaved order.
// - Test port samples on test clock rise, updates serial output on fall.
// - Interleaved order: start value XOR 01, 10, 11.
// - Linear order: start value plus one modulo four.
// - Write is active on global write low or qualify plus any lane low.
`timescale 1ns/1ps
module sbsa_top #(
	parameter int ADDR_W = 10
) (
	// Clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          arst_n_in,
	// Address and selects
	input  wire logic [ADDR_W-1:0]             addr_in,
	input  wire logic                          chip_sel_first_n_in,
	input  wire logic                          chip_sel_second_in,
	input  wire logic                          chip_sel_third_n_in,
	// Burst control
	input  wire logic                          processor_addr_strobe_n_in,
	input  wire logic                          controller_addr_strobe_n_in,
	input  wire logic                          burst_advance_n_in,
	input  wire logic                          burst_order_strap_in,
	// Write control
	input  wire logic                          global_write_n_in,
	input  wire logic                          byte_write_qualify_n_in,
	input  wire logic [sbsa_pkg::SBSA_LANES-1:0] byte_lane_select_n_in,
	// Data pins
	input  wire logic                          output_enable_n_in,
	input  wire logic [sbsa_pkg::SBSA_DATA_W-1:0] dq_in,
	output logic      [sbsa_pkg::SBSA_DATA_W-1:0] dq_out,
	output logic                               dq_oe_out,
	// Test port
	input  wire logic                          test_clk_in,
	input  wire logic                          test_data_in,
	input  wire logic                          test_mode_sel_in,
	output logic                               test_data_out
);
	import sbsa_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;

	logic [SBSA_DATA_W-1:0] core_mem [DEPTH];

	sbsa_state_type          state_q, state_d;
	logic [ADDR_W-1:0]       addr_q, addr_d;
	logic [1:0]              start_q, start_d;
	logic [1:0]              step_q, step_d;
	logic [SBSA_DATA_W-1:0]  din_q;
	logic                    mode_meta_q, mode_q;
	logic [2:0]              tck_q;
	logic                    tdi_meta_q, tdi_q, tms_meta_q, tms_q;
	logic                    shift_q, shift_d, mode_sel_q, mode_sel_d, tdo_q, tdo_d;
	logic                    wr_en;
	logic [ADDR_W-1:0]       wr_addr;
	logic                    sel, p_go, c_go, wr_ind;
	logic [1:0]              next_step;

	function automatic logic write_cond(input logic gw_n, input logic bwe_n,
		input logic [SBSA_LANES-1:0] bw_n);
		return !gw_n || (!bwe_n && !(&bw_n));
	endfunction

	function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] step,
		input logic interleave);
		return interleave ? (start ^ step) : 2'(start + step);
	endfunction

	// Core address in use right now
	wire [1:0]        cur_low  = burst_low(start_q, step_q, mode_q);
	wire [ADDR_W-1:0] cur_addr = {addr_q[ADDR_W-1:SBSA_BURST_W], cur_low};

	always_comb begin
		sel       = !chip_sel_first_n_in && chip_sel_second_in && !chip_sel_third_n_in;
		p_go      = !chip_sel_first_n_in && !processor_addr_strobe_n_in;
		c_go      = !controller_addr_strobe_n_in && !p_go;
		wr_ind    = write_cond(global_write_n_in, byte_write_qualify_n_in, byte_lane_select_n_in);
		next_step = burst_advance_n_in ? step_q : 2'(step_q + SBSA_STEP_ONE);
		state_d   = state_q;
		addr_d    = addr_q;
		start_d   = start_q;
		step_d    = step_q;
		wr_en     = 1'b0;
		wr_addr   = cur_addr;
		if (p_go || c_go) begin
			if (!sel) begin
				state_d = SBSA_ST_DESEL;
			end else begin
				addr_d  = addr_in;
				start_d = addr_in[1:0];
				step_d  = SBSA_STEP_RST;
				if (c_go && wr_ind) begin
					state_d = SBSA_ST_WRITE;
					wr_en   = 1'b1;
					wr_addr = addr_in;
				end else begin
					state_d = SBSA_ST_READ;
				end
			end
		end else if (state_q != SBSA_ST_DESEL) begin
			step_d  = next_step;
			wr_addr = {addr_q[ADDR_W-1:SBSA_BURST_W], burst_low(start_q, next_step, mode_q)};
			wr_en   = wr_ind;
			state_d = wr_ind ? SBSA_ST_WRITE : SBSA_ST_READ;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q     <= SBSA_ST_DESEL;
			addr_q      <= '0;
			start_q     <= SBSA_STEP_RST;
			step_q      <= SBSA_STEP_RST;
			din_q       <= '0;
			mode_meta_q <= SBSA_MODE_RST;
			mode_q      <= SBSA_MODE_RST;
		end else begin
			state_q     <= state_d;
			addr_q      <= addr_d;
			start_q     <= start_d;
			step_q      <= step_d;
			din_q       <= dq_in;
			mode_meta_q <= burst_order_strap_in;
			mode_q      <= mode_meta_q;
		end
	end

	// Core has no reset; contents are undefined until written
	for (genvar ln = 0; ln < SBSA_LANES; ln++) begin : g_lane
		always_ff @(posedge clk_in) begin
			if (wr_en && (!global_write_n_in || !byte_lane_select_n_in[ln])) begin
				core_mem[wr_addr][ln*SBSA_LANE_W +: SBSA_LANE_W] <= dq_in[ln*SBSA_LANE_W +: SBSA_LANE_W];
			end
		end
	end

	// Flow-through: no output stage, so data trails the address register directly
	assign dq_out    = core_mem[cur_addr];
	// Enable is gated live by the pin so it turns around without waiting a clock
	assign dq_oe_out = (state_q == SBSA_ST_READ) && !output_enable_n_in;

	// Test port: pins are synchronised, so test clock must stay well below clk_in
	always_comb begin
		shift_d    = shift_q;
		mode_sel_d = mode_sel_q;
		tdo_d      = tdo_q;
		if (tck_q[1] && !tck_q[2]) begin
			shift_d    = tdi_q;
			mode_sel_d = tms_q;
		end
		if (!tck_q[1] && tck_q[2]) begin
			tdo_d = shift_q;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tck_q      <= 3'h0;
			tdi_meta_q <= 1'b0;
			tdi_q      <= 1'b0;
			tms_meta_q <= 1'b0;
			tms_q      <= 1'b0;
			shift_q    <= 1'b0;
			mode_sel_q <= 1'b0;
			tdo_q      <= 1'b0;
		end else begin
			tck_q      <= {tck_q[1:0], test_clk_in};
			tdi_meta_q <= test_data_in;
			tdi_q      <= tdi_meta_q;
			tms_meta_q <= test_mode_sel_in;
			tms_q      <= tms_meta_q;
			shift_q    <= shift_d;
			mode_sel_q <= mode_sel_d;
			tdo_q      <= tdo_d;
		end
	end

	assign test_data_out = tdo_q;

	sequence s_sel_start;
		!chip_sel_first_n_in && chip_sel_second_in && !chip_sel_third_n_in &&
		(!processor_addr_strobe_n_in || !controller_addr_strobe_n_in);
	endsequence

	sequence s_cont;
		processor_addr_strobe_n_in && controller_addr_strobe_n_in && state_q != SBSA_ST_DESEL;
	endsequence

	AST_INREG: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		1'b1 |=> din_q == $past(dq_in)) else $error("data input register missed a sample");
	AST_START_LOAD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		s_sel_start |=> state_q != SBSA_ST_DESEL && addr_q == $past(addr_in) && step_q == 2'h0)
		else $error("selected start did not load address");
	AST_P_IGNORED: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		chip_sel_first_n_in && !processor_addr_strobe_n_in && controller_addr_strobe_n_in
		|=> $stable(addr_q)) else $error("processor strobe acted with first select high");
	AST_P_READ: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		s_sel_start and !processor_addr_strobe_n_in |=> state_q == SBSA_ST_READ)
		else $error("processor start did not begin as read");
	AST_C_WRITE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		s_sel_start and processor_addr_strobe_n_in and wr_ind |=> state_q == SBSA_ST_WRITE)
		else $error("controller write start missed");
	AST_P_THEN_W: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(s_sel_start and !processor_addr_strobe_n_in) ##1 (s_cont and wr_ind) |-> wr_en)
		else $error("write after processor start not performed");
	AST_OE_ASYNC: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		output_enable_n_in |-> !dq_oe_out) else $error("data driven with output enable high");
	AST_WR_FLOAT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		state_q == SBSA_ST_WRITE |-> !dq_oe_out) else $error("data driven during write");
	AST_HOLD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		s_cont and burst_advance_n_in |=> $stable(step_q)) else $error("counter moved without advance");
	AST_ORDER: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		s_cont and !burst_advance_n_in |=> cur_low == (mode_q ? ($past(start_q) ^ $past(step_q + 2'h1))
		: 2'($past(start_q) + $past(step_q) + 2'h1))) else $error("wrong burst address order");
	AST_TDO_FALL: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$changed(tdo_q) |-> $past(tck_q[2]) && !$past(tck_q[1])) else $error("serial output moved off falling edge");
	AST_TDI_RISE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		tck_q[1] && !tck_q[2] |=> shift_q == $past(tdi_q) && mode_sel_q == $past(tms_q))
		else $error("serial inputs missed the test clock rise");
endmodule

// file: dv/sbsa_bus_master.sv
// Bus master side of the shared data wire: resolves the level seen at the pins.
// Assumes the bench tells it when the master drives write data.
`timescale 1ns/1ps
module sbsa_bus_master (
	// Clock
	input  wire logic        clk_in,
	// Master data
	input  wire logic        drive_in,
	input  wire logic [31:0] wdata_in,
	// Device data
	input  wire logic [31:0] dq_out_in,
	input  wire logic        dq_oe_in,
	output logic      [31:0] dq_wire_out
);
	logic [31:0] last_q = 32'h0;
	always_ff @(posedge clk_in)
		last_q <= dq_wire_out;
	// Floating wire shows a changing pattern, not a stale value
	always_comb
		if (drive_in) dq_wire_out = wdata_in;
		else if (dq_oe_in) dq_wire_out = dq_out_in;
		else dq_wire_out = ~last_q;
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the burst SRAM front end: corner and random bus cycles.
// Assumes sbsa_top and the bus master model beside it.
`timescale 1ns/1ps
module tb_top;
	import sbsa_pkg::*;
	logic        clk = 0, rst_n = 0, ps_n = 1, cs_n = 1, adv_n = 1, strap = 1, gw_n = 1, bwe_n = 1, oe_n = 1;
	logic        drv = 0, tck = 0, tdi = 0, tms = 0, tdo, dq_oe, il = 1;
	logic [2:0]  ce = 3'h7;
	logic [3:0]  addr = 4'h0, bs_n = 4'hf, base = 4'h0, cur;
	logic [1:0]  cnt = 2'h0, st = 2'h0;
	logic [31:0] wdat = 32'h0, dq_out, dq_wire, rnd = 32'h49ea;
	logic [31:0] mem [16];
	int          error_cnt = 0, checks = 0;

	sbsa_top #(.ADDR_W(4)) dut (.clk_in(clk), .arst_n_in(rst_n), .addr_in(addr), .chip_sel_first_n_in(ce[2]),
		.chip_sel_second_in(ce[1]), .chip_sel_third_n_in(ce[0]), .processor_addr_strobe_n_in(ps_n),
		.controller_addr_strobe_n_in(cs_n), .burst_advance_n_in(adv_n), .burst_order_strap_in(strap),
		.global_write_n_in(gw_n), .byte_write_qualify_n_in(bwe_n), .byte_lane_select_n_in(bs_n),
		.output_enable_n_in(oe_n), .dq_in(dq_wire), .dq_out(dq_out), .dq_oe_out(dq_oe), .test_clk_in(tck),
		.test_data_in(tdi), .test_mode_sel_in(tms), .test_data_out(tdo));
	sbsa_bus_master bm (.clk_in(clk), .drive_in(drv), .wdata_in(wdat), .dq_out_in(dq_out), .dq_oe_in(dq_oe),
		.dq_wire_out(dq_wire));

	initial forever #20 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// v = {proc strobe, ctrl strobe, advance, global write, qualify}, all low active
	task automatic cyc(input logic [2:0] c, input logic [4:0] v, input logic [3:0] s, ad, input logic o);
		logic pgo, wc;
		@(negedge clk);
		pgo = !c[2] && !v[4];
		wc = !v[1] || (!v[0] && s != 4'hf);
		rnd = xs(rnd);
		{ce, ps_n, cs_n, adv_n, gw_n, bwe_n, bs_n, addr} = {c, v, s, ad};
		drv = wc;
		wdat = rnd;
		oe_n = wc | o;
		@(posedge clk);
		if (pgo || !v[3]) begin
			st = (c != 3'h2) ? 2'h0 : (!pgo && wc) ? 2'h2 : 2'h1;
			base = ad;
			cnt = 2'h0;
		end else if (st != 2'h0) begin
			cnt = cnt + {1'b0, !v[2]};
			st = wc ? 2'h2 : 2'h1;
		end
		cur = {base[3:2], il ? base[1:0] ^ cnt : base[1:0] + cnt};
		for (int i = 0; i < 4; i++)
			if (st == 2'h2 && (!v[1] || (!v[0] && !s[i]))) mem[cur][8*i+:8] = wdat[8*i+:8];
		#1;
		chk({31'h0, dq_oe}, {31'h0, st == 2'h1 && !oe_n});
		if (st == 2'h1) chk(dq_out, mem[cur]);
		if (st == 2'h2) begin
			// Enable pulled low mid write must still leave the pins floating
			oe_n = 1'b0;
			#1;
			chk({31'h0, dq_oe}, 32'h0);
		end
	endtask

	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		for (int i = 0; i < 16; i++) cyc(3'h2, 5'h15, 4'hf, i[3:0], 1'b0);
		cyc(3'h2, 5'h05, 4'hf, 4'h6, 1'b0);
		cyc(3'h2, 5'h1e, 4'hb, 4'h0, 1'b0);
		cyc(3'h6, 5'h0f, 4'hf, 4'h3, 1'b0);
		for (int m = 0; m < 2; m++) begin
			strap = m[0];
			repeat (3) cyc(3'h7, 5'h17, 4'hf, 4'h0, 1'b0);
			il = m[0];
			cyc(3'h2, 5'h0f, 4'hf, 4'h7, 1'b0);
			repeat (4) cyc(3'h2, 5'h1b, 4'hf, 4'h0, 1'b0);
			cyc(3'h2, 5'h1f, 4'hf, 4'h0, 1'b0);
			repeat (150) begin
				rnd = xs(rnd);
				cyc(rnd[0] ? 3'h2 : rnd[3:1], {rnd[6:4], rnd[7] | rnd[8], rnd[9]}, rnd[13:10], rnd[17:14], rnd[18]);
			end
		end
		repeat (8) begin
			rnd = xs(rnd);
			@(negedge clk) {tdi, tms, tck} = {rnd[1:0], 1'b1};
			repeat (6) @(negedge clk);
			tck = 1'b0;
			repeat (6) @(negedge clk);
			chk({31'h0, tdo}, {31'h0, tdi});
		end
		close_out();
	end

	// Run needs about 500 cycles
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule
